// File: ippc_pkg.sv
package ippc_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int SETTLE_US = 40;
	localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
	localparam int FIX_FREQ_HZ = 127_700;
	localparam longint NCO_L = (longint'(FIX_FREQ_HZ) * 64'sd16777216 + CLK_HZ / 2) / CLK_HZ;
	localparam logic [23:0] NCO_FIXED = 24'(NCO_L);
	localparam int LED_STEP_MS = 125;
	localparam int LED_STEP_CYC = LED_STEP_MS * (CLK_HZ / 1000);
	localparam int XTAL_HZ = 8_000_000;
	localparam logic [3:0] GAP_MAX = 4'(CLK_HZ / XTAL_HZ + 2);
	localparam logic [7:0] LOCK_EDGES = 8'hff;
	// ---------------------------------------------------------------
	// serial ports
	// ---------------------------------------------------------------
	localparam logic [6:0] I2C_ADDR = 7'h61;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_PROG = 8'h02;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_PING = 8'h00;
	localparam logic [7:0] REG_FOD = 8'h01;
	localparam logic [7:0] REG_ILIM = 8'h02;
	localparam logic [7:0] REG_LED = 8'h03;
	localparam logic [7:0] REG_FADDR_H = 8'h04;
	localparam logic [7:0] REG_FADDR_L = 8'h05;
	localparam logic [7:0] REG_FDATA = 8'h06;
	localparam logic [7:0] REG_FCMD = 8'h07;
	localparam logic [7:0] REG_PWM = 8'h08;
	localparam logic [7:0] REG_FREQ_H = 8'h09;
	localparam logic [7:0] REG_FREQ_L = 8'h0a;
	localparam logic [7:0] REG_STAT = 8'h0b;
	localparam logic [7:0] REG_N = 8'h0b;
	localparam logic [7:0] FCMD_PROG = 8'h01;
	localparam logic [7:0] PING_RST = 8'h40;
	localparam logic [7:0] FOD_RST = 8'h20;
	localparam logic [7:0] ILIM_RST = 8'h80;
	localparam logic [7:0] LED_RST = 8'h0f;
	localparam logic [7:0] PWM_RST = 8'h80;
	localparam logic [7:0] FREQ_H_RST = 8'h01;
	localparam logic [7:0] FREQ_L_RST = 8'h80;
	// ---------------------------------------------------------------
	// power levels
	// ---------------------------------------------------------------
	localparam logic [4:0] W_BASE = 5'h05;
	localparam logic [4:0] W_9 = 5'h08;
	localparam logic [4:0] W_12 = 5'h0a;
	localparam logic [4:0] W_HI = 5'h0f;

	typedef enum logic [1:0] {
		LVL_5V = 2'b00, LVL_9V = 2'b01, LVL_12V = 2'b10, LVL_HI = 2'b11
	} ippc_level_t;
	typedef enum logic [2:0] {
		PORT_NONE = 3'b000, PORT_DC = 3'b001, PORT_SDP = 3'b010,
		PORT_CDP = 3'b011, PORT_DCP = 3'b100
	} ippc_port_t;
	typedef enum logic [2:0] {
		P_WAIT = 3'b000, P_DCD = 3'b001, P_PRI = 3'b010, P_SEC = 3'b011, P_DONE = 3'b100
	} ippc_pst_t;
	typedef enum logic [2:0] {
		F_LOCK = 3'b000, F_BOOT = 3'b001, F_IDLE = 3'b010,
		F_WREN = 3'b011, F_GAP = 3'b100, F_PROG = 3'b101
	} ippc_fst_t;
	typedef struct packed {
		logic ext_ok;
		logic [4:0] max_w;
		logic buck_en;
		logic bypass_en;
	} ippc_profile_t;
endpackage

// File: ippc_spi_byte.sv
module ippc_spi_byte #(
	parameter int DIV = 4
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [7:0] tx_i,
	output logic [7:0] rx_o,
	output logic done_o,
	output logic busy_o,
	output logic sck_o,
	output logic mosi_o,
	input wire logic miso_i
);
	// ---------------------------------------------------------------
	// mode 0 byte shifter
	// ---------------------------------------------------------------
	logic [1:0] miso_s;
	logic [15:0] div_r;
	logic [7:0] sh_r;
	logic [2:0] bit_r;
	logic tick;

	assign tick = div_r == 16'(DIV - 1);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			miso_s <= '0;
		end else begin
			miso_s <= {miso_s[0], miso_i};
		end
	end

	// miso sampled late in the high phase so the sync delay fits
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			div_r <= '0;
			sh_r <= '0;
			bit_r <= '0;
			rx_o <= '0;
			done_o <= 1'h0;
			busy_o <= 1'h0;
			sck_o <= 1'h0;
			mosi_o <= 1'h0;
		end else begin
			done_o <= 1'h0;
			if (!busy_o) begin
				div_r <= '0;
				if (start_i) begin
					busy_o <= 1'h1;
					sh_r <= tx_i;
					mosi_o <= tx_i[7];
					bit_r <= '0;
				end
			end else if (!tick) begin
				div_r <= div_r + 16'h0001;
			end else begin
				div_r <= '0;
				if (!sck_o) begin
					sck_o <= 1'h1;
				end else begin
					sck_o <= 1'h0;
					rx_o <= {rx_o[6:0], miso_s[1]};
					sh_r <= {sh_r[6:0], 1'h0};
					mosi_o <= sh_r[6];
					bit_r <= bit_r + 3'h1;
					if (bit_r == 3'h7) begin
						busy_o <= 1'h0;
						done_o <= 1'h1;
					end
				end
			end
		end
	end
endmodule

// File: ippc_i2c_tgt.sv
module ippc_i2c_tgt (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_oe_o,
	output logic wr_o,
	output logic [7:0] ptr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_PTR = 3'b010, S_WR = 3'b011, S_RD = 3'b100
	} ippc_ist_t;

	// ---------------------------------------------------------------
	// line sync and edges
	// ---------------------------------------------------------------
	logic [1:0] s1, s2, s3;
	logic scl, sda, rise, fall, start, stop;
	ippc_ist_t st_r;
	logic ack_r, inc_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r, tx_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s1 <= 2'h3;
			s2 <= 2'h3;
			s3 <= 2'h3;
		end else begin
			s1 <= {scl_i, sda_i};
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign scl = s2[1];
	assign sda = s2[0];
	assign rise = scl & ~s3[1];
	assign fall = ~scl & s3[1];
	assign start = scl & s3[1] & ~sda & s3[0];
	assign stop = scl & s3[1] & sda & ~s3[0];

	// ---------------------------------------------------------------
	// byte engine
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_r <= S_IDLE;
			ack_r <= 1'h0;
			inc_r <= 1'h0;
			cnt_r <= '0;
			sh_r <= '0;
			tx_r <= '0;
			ptr_o <= '0;
			wdata_o <= '0;
			wr_o <= 1'h0;
			sda_oe_o <= 1'h0;
		end else begin
			wr_o <= 1'h0;
			if (start) begin
				st_r <= S_ADDR;
				ack_r <= 1'h0;
				cnt_r <= '0;
				sda_oe_o <= 1'h0;
			end else if (stop) begin
				st_r <= S_IDLE;
				sda_oe_o <= 1'h0;
			end else if (st_r != S_IDLE && rise) begin
				if (!ack_r) begin
					sh_r <= {sh_r[6:0], sda};
					cnt_r <= cnt_r + 4'h1;
				end else if (st_r == S_RD && sda) begin
					// not-acknowledge ends the read burst
					st_r <= S_IDLE;
				end
			end else if (st_r != S_IDLE && fall) begin
				if (!ack_r && cnt_r == 4'h8) begin
					ack_r <= 1'h1;
					cnt_r <= '0;
					case (st_r)
						S_ADDR: begin
							if (sh_r[7:1] == ippc_pkg::I2C_ADDR) begin
								sda_oe_o <= 1'h1;
								st_r <= sh_r[0] ? S_RD : S_PTR;
							end else begin
								st_r <= S_IDLE;
							end
						end
						S_PTR: begin
							// pointer byte itself must not advance the pointer
							ptr_o <= sh_r;
							inc_r <= 1'h0;
							sda_oe_o <= 1'h1;
							st_r <= S_WR;
						end
						S_WR: begin
							wdata_o <= sh_r;
							wr_o <= 1'h1;
							inc_r <= 1'h1;
							sda_oe_o <= 1'h1;
						end
						default: begin
							sda_oe_o <= 1'h0;
						end
					endcase
				end else if (ack_r) begin
					ack_r <= 1'h0;
					if (st_r == S_WR && inc_r) begin
						ptr_o <= ptr_o + 8'h01;
					end
					if (st_r == S_RD) begin
						tx_r <= rdata_i;
						sda_oe_o <= ~rdata_i[7];
						ptr_o <= ptr_o + 8'h01;
					end else begin
						sda_oe_o <= 1'h0;
					end
				end else if (st_r == S_RD) begin
					tx_r <= {tx_r[6:0], 1'h0};
					sda_oe_o <= ~tx_r[6];
				end
			end
		end
	end
endmodule

// File: ippc_top.sv
module ippc_top #(
	parameter int LED_STEP = ippc_pkg::LED_STEP_CYC,
	parameter int BOOT_LEN = 16,
	parameter int SPI_DIV = 4
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic adaptor_present_i,
	input wire logic [1:0] input_level_i,
	input wire logic dminus_sense_pin_a_i,
	output logic dminus_sense_pin_a_o,
	output logic dminus_sense_pin_a_oe_o,
	input wire logic dminus_sense_pin_b_i,
	output logic dminus_sense_pin_b_o,
	output logic dminus_sense_pin_b_oe_o,
	input wire logic dplus_sense_pin_i,
	output logic dplus_sense_pin_o,
	output logic dplus_sense_pin_oe_o,
	output logic buck_enable_out_o,
	output logic buck_trim_pwm_out_o,
	output logic buck_bypass_out_o,
	output logic bridge_drive_o,
	input wire logic crystal_pin_in_i,
	output logic crystal_pin_out_o,
	output logic xtal_locked_o,
	output logic flash_port_pin_0_o,
	output logic flash_port_pin_1_o,
	output logic flash_port_pin_2_o,
	input wire logic flash_port_pin_3_i,
	output logic [7:0] fetch_data_o,
	output logic fetch_valid_o,
	output logic boot_done_o,
	input wire logic serial_clock_pin_i,
	input wire logic serial_data_pin_i,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe_o,
	input wire logic former_threshold_pin_i,
	input wire logic former_pattern_pin_i,
	input wire logic fault_i,
	output logic status_indicator_one_o,
	output logic status_indicator_two_o,
	output logic [2:0] port_type_o,
	output ippc_pkg::ippc_profile_t profile_o,
	output logic [1:0] vreq_level_o,
	output logic [7:0] ping_freq_o,
	output logic [7:0] fod_thresh_o,
	output logic [7:0] ilim_o
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic ippc_pkg::ippc_profile_t prof_of(ippc_pkg::ippc_level_t l);
		ippc_pkg::ippc_profile_t p;
		p = '0;
		p.max_w = ippc_pkg::W_BASE;
		case (l)
			ippc_pkg::LVL_5V: p.bypass_en = 1'h1;
			ippc_pkg::LVL_9V: p = {1'h1, ippc_pkg::W_9, 1'h1, 1'h0};
			ippc_pkg::LVL_12V: p = {1'h1, ippc_pkg::W_12, 1'h1, 1'h0};
			default: p = {1'h1, ippc_pkg::W_HI, 1'h1, 1'h0};
		endcase
		return p;
	endfunction

	function automatic logic [7:0] cfg_rst(int i);
		case (i)
			0: return ippc_pkg::PING_RST;
			1: return ippc_pkg::FOD_RST;
			2: return ippc_pkg::ILIM_RST;
			3: return ippc_pkg::LED_RST;
			8: return ippc_pkg::PWM_RST;
			9: return ippc_pkg::FREQ_H_RST;
			10: return ippc_pkg::FREQ_L_RST;
			default: return 8'h00;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// pin sync
	// ---------------------------------------------------------------
	logic [5:0] sy1, sy2;
	logic att, dm, dp, xt;
	ippc_pkg::ippc_level_t lvl;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sy1 <= '0;
			sy2 <= '0;
		end else begin
			sy1 <= {adaptor_present_i, input_level_i, dminus_sense_pin_a_i,
				dplus_sense_pin_i, crystal_pin_in_i};
			sy2 <= sy1;
		end
	end

	assign att = sy2[5];
	assign lvl = ippc_pkg::ippc_level_t'(sy2[4:3]);
	assign dm = sy2[2];
	assign dp = sy2[1];
	assign xt = sy2[0];

	// ---------------------------------------------------------------
	// port detection
	// ---------------------------------------------------------------
	ippc_pkg::ippc_pst_t pst_r;
	ippc_pkg::ippc_port_t port_r;
	logic [15:0] tmr_r;
	logic tmo, dp_drv_r, dmb_drv_r, zero_r;

	assign tmo = tmr_r == 16'(ippc_pkg::SETTLE_CYC - 1);

	always_ff @(posedge mclk_i) begin
		if (rst_i || !att) begin
			pst_r <= ippc_pkg::P_WAIT;
			port_r <= ippc_pkg::PORT_NONE;
			tmr_r <= '0;
			dp_drv_r <= 1'h0;
			dmb_drv_r <= 1'h0;
		end else begin
			tmr_r <= (tmo || pst_r == ippc_pkg::P_WAIT) ? 16'h0000 : tmr_r + 16'h0001;
			case (pst_r)
				ippc_pkg::P_WAIT: pst_r <= ippc_pkg::P_DCD;
				ippc_pkg::P_DCD: begin
					// line left high means no host pulldown
					if (tmo && dp) begin
						port_r <= ippc_pkg::PORT_DC;
						pst_r <= ippc_pkg::P_DONE;
					end else if (tmo) begin
						dp_drv_r <= 1'h1;
						pst_r <= ippc_pkg::P_PRI;
					end
				end
				ippc_pkg::P_PRI: begin
					if (tmo) begin
						dp_drv_r <= 1'h0;
						dmb_drv_r <= dm;
						port_r <= dm ? ippc_pkg::PORT_NONE : ippc_pkg::PORT_SDP;
						pst_r <= dm ? ippc_pkg::P_SEC : ippc_pkg::P_DONE;
					end
				end
				ippc_pkg::P_SEC: begin
					// secondary step tells dedicated from host port
					if (tmo) begin
						dmb_drv_r <= 1'h0;
						port_r <= dp ? ippc_pkg::PORT_DCP : ippc_pkg::PORT_CDP;
						pst_r <= ippc_pkg::P_DONE;
					end
				end
				default: pst_r <= ippc_pkg::P_DONE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		zero_r <= 1'h0;
	end

	assign dminus_sense_pin_a_o = zero_r;
	assign dminus_sense_pin_a_oe_o = zero_r;
	assign dminus_sense_pin_b_o = dmb_drv_r;
	assign dminus_sense_pin_b_oe_o = dmb_drv_r;
	assign dplus_sense_pin_o = dp_drv_r;
	assign dplus_sense_pin_oe_o = dp_drv_r;
	assign serial_data_pin_o = zero_r;
	assign port_type_o = port_r;

	// ---------------------------------------------------------------
	// profile selection
	// ---------------------------------------------------------------
	ippc_pkg::ippc_profile_t prof_r;
	ippc_pkg::ippc_level_t vreq_r, eff;
	logic usb;

	assign usb = port_r != ippc_pkg::PORT_DC && port_r != ippc_pkg::PORT_NONE;
	// charging ports capped at twelve volts
	assign eff = (usb && lvl == ippc_pkg::LVL_HI) ? ippc_pkg::LVL_12V : lvl;

	always_ff @(posedge mclk_i) begin
		if (rst_i || pst_r != ippc_pkg::P_DONE) begin
			prof_r <= '0;
			vreq_r <= ippc_pkg::LVL_5V;
		end else begin
			// five volt source selects bypass path
			prof_r <= prof_of(eff);
			vreq_r <= eff;
		end
	end

	assign profile_o = prof_r;
	assign vreq_level_o = vreq_r;
	assign buck_enable_out_o = prof_r.buck_en;
	assign buck_bypass_out_o = prof_r.bypass_en;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] cfg_r [0:10];
	logic [7:0] rdata_r, ptr, wdata;
	logic i2c_wr, prog_req_r, prog_take_r, flash_busy, sda_oe;
	ippc_pkg::ippc_fst_t fst_r;

	// target port on clock and data pins
	ippc_i2c_tgt u_i2c (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.scl_i(serial_clock_pin_i),
		.sda_i(serial_data_pin_i),
		.sda_oe_o(sda_oe),
		.wr_o(i2c_wr),
		.ptr_o(ptr),
		.wdata_o(wdata),
		.rdata_i(rdata_r)
	);

	assign serial_data_pin_oe_o = sda_oe;
	assign flash_busy = fst_r != ippc_pkg::F_IDLE;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 11; i++) begin
				cfg_r[i] <= cfg_rst(i);
			end
		end else if (i2c_wr && ptr < ippc_pkg::REG_N) begin
			// parameters written over the serial port
			cfg_r[ptr[3:0]] <= wdata;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_r <= '0;
		end else if (ptr == ippc_pkg::REG_STAT) begin
			rdata_r <= {boot_done_o, xtal_locked_o, flash_busy, port_r, vreq_r};
		end else if (ptr < ippc_pkg::REG_N) begin
			rdata_r <= cfg_r[ptr[3:0]];
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// set wins over the take in the same cycle
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prog_req_r <= 1'h0;
		end else if (i2c_wr && ptr == ippc_pkg::REG_FCMD && wdata == ippc_pkg::FCMD_PROG) begin
			prog_req_r <= 1'h1;
		end else if (prog_take_r) begin
			prog_req_r <= 1'h0;
		end
	end

	assign ping_freq_o = cfg_r[0];
	assign fod_thresh_o = cfg_r[1];
	assign ilim_o = cfg_r[2];

	// ---------------------------------------------------------------
	// buck trim and bridge timing
	// ---------------------------------------------------------------
	logic [7:0] pwm_cnt_r;
	logic pwm_r;
	logic [23:0] acc_r, inc;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pwm_cnt_r <= '0;
			pwm_r <= 1'h0;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + 8'h01;
			pwm_r <= prof_r.buck_en && (pwm_cnt_r < cfg_r[8]);
		end
	end

	assign buck_trim_pwm_out_o = pwm_r;
	// fixed phase step in buck mode
	assign inc = prof_r.bypass_en ? {cfg_r[9], cfg_r[10], 8'h00} : ippc_pkg::NCO_FIXED;

	always_ff @(posedge mclk_i) begin
		if (rst_i || pst_r != ippc_pkg::P_DONE) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_r + inc;
		end
	end

	assign bridge_drive_o = acc_r[23];

	// ---------------------------------------------------------------
	// crystal drive and lock
	// ---------------------------------------------------------------
	// lock gates the boot read: an 8MHz tone sampled at 20MHz shows edges 2 to 3 cycles apart
	logic xo_r, xprev_r, lock_r;
	logic [3:0] gap_r;
	logic [7:0] lcnt_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			xo_r <= 1'h0;
			xprev_r <= 1'h0;
			gap_r <= '0;
			lcnt_r <= '0;
			lock_r <= 1'h0;
		end else begin
			xo_r <= ~xt;
			xprev_r <= xt;
			lock_r <= lcnt_r == ippc_pkg::LOCK_EDGES;
			if (xt && !xprev_r) begin
				gap_r <= '0;
				if (lcnt_r != ippc_pkg::LOCK_EDGES) begin
					lcnt_r <= lcnt_r + 8'h01;
				end
			end else if (gap_r > ippc_pkg::GAP_MAX) begin
				lcnt_r <= '0;
			end else begin
				gap_r <= gap_r + 4'h1;
			end
		end
	end

	assign crystal_pin_out_o = xo_r;
	assign xtal_locked_o = lock_r;

	// ---------------------------------------------------------------
	// flash sequencer
	// ---------------------------------------------------------------
	logic [15:0] idx_r, last;
	logic [7:0] byte_r, rx, nxt_byte;
	logic cs_n_r, st_r, sdone, sbusy, fvalid_r, bdone_r;
	logic [7:0] fdata_r;

	assign last = fst_r == ippc_pkg::F_BOOT ? 16'(BOOT_LEN + 3) :
		(fst_r == ippc_pkg::F_PROG ? 16'h0004 : 16'h0000);

	always_comb begin
		nxt_byte = 8'h00;
		if (fst_r == ippc_pkg::F_PROG) begin
			case (idx_r + 16'h0001)
				16'h0002: nxt_byte = cfg_r[4];
				16'h0003: nxt_byte = cfg_r[5];
				16'h0004: nxt_byte = cfg_r[6];
				default: nxt_byte = 8'h00;
			endcase
		end
	end

	ippc_spi_byte #(.DIV(SPI_DIV)) u_spi (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.start_i(st_r),
		.tx_i(byte_r),
		.rx_o(rx),
		.done_o(sdone),
		.busy_o(sbusy),
		.sck_o(flash_port_pin_1_o),
		.mosi_o(flash_port_pin_2_o),
		.miso_i(flash_port_pin_3_i)
	);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fst_r <= ippc_pkg::F_LOCK;
			idx_r <= '0;
			byte_r <= '0;
			cs_n_r <= 1'h1;
			st_r <= 1'h0;
			prog_take_r <= 1'h0;
			fvalid_r <= 1'h0;
			fdata_r <= '0;
			bdone_r <= 1'h0;
		end else begin
			st_r <= 1'h0;
			prog_take_r <= 1'h0;
			fvalid_r <= 1'h0;
			case (fst_r)
				ippc_pkg::F_LOCK: begin
					// boot read once the clock is locked
					if (lock_r) begin
						fst_r <= ippc_pkg::F_BOOT;
						{cs_n_r, st_r, byte_r} <= {1'h0, 1'h1, ippc_pkg::CMD_READ};
					end
				end
				ippc_pkg::F_IDLE: begin
					// queued code byte goes to flash
					if (prog_req_r) begin
						prog_take_r <= 1'h1;
						fst_r <= ippc_pkg::F_WREN;
						{cs_n_r, st_r, byte_r} <= {1'h0, 1'h1, ippc_pkg::CMD_WREN};
					end
				end
				ippc_pkg::F_GAP: begin
					fst_r <= ippc_pkg::F_PROG;
					{cs_n_r, st_r, byte_r} <= {1'h0, 1'h1, ippc_pkg::CMD_PROG};
				end
				default: begin
					if (sdone && fst_r == ippc_pkg::F_BOOT && idx_r > 16'h0003) begin
						fdata_r <= rx;
						fvalid_r <= 1'h1;
					end
					if (sdone && idx_r == last) begin
						cs_n_r <= 1'h1;
						idx_r <= '0;
						bdone_r <= bdone_r | (fst_r == ippc_pkg::F_BOOT);
						fst_r <= fst_r == ippc_pkg::F_WREN ? ippc_pkg::F_GAP : ippc_pkg::F_IDLE;
					end else if (sdone) begin
						idx_r <= idx_r + 16'h0001;
						st_r <= 1'h1;
						byte_r <= nxt_byte;
					end
				end
			endcase
		end
	end

	assign flash_port_pin_0_o = cs_n_r;
	assign fetch_data_o = fdata_r;
	assign fetch_valid_o = fvalid_r;
	assign boot_done_o = bdone_r;

	// ---------------------------------------------------------------
	// indicators
	// ---------------------------------------------------------------
	logic [23:0] lcyc_r;
	logic [2:0] step_r;
	logic status_indicator_one_r, status_indicator_two_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			lcyc_r <= '0;
			step_r <= '0;
			status_indicator_one_r <= 1'h0;
			status_indicator_two_r <= 1'h0;
		end else begin
			// pattern bits stepped by slow tick
			if (lcyc_r == 24'(LED_STEP - 1)) begin
				lcyc_r <= '0;
				step_r <= step_r + 3'h1;
			end else begin
				lcyc_r <= lcyc_r + 24'h000001;
			end
			status_indicator_one_r <= pst_r == ippc_pkg::P_DONE && cfg_r[3][step_r];
			status_indicator_two_r <= fault_i ? step_r[0] : prof_r.ext_ok;
		end
	end

	assign status_indicator_one_o = status_indicator_one_r;
	assign status_indicator_two_o = status_indicator_two_r;
endmodule

// File: ippc_top_properties.sv
module ippc_top_properties (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic dminus_sense_pin_a_oe_o,
	input wire logic dplus_sense_pin_oe_o,
	input wire logic buck_enable_out_o,
	input wire logic buck_trim_pwm_out_o,
	input wire logic buck_bypass_out_o,
	input wire logic flash_port_pin_0_o,
	input wire logic flash_port_pin_1_o,
	input wire logic fetch_valid_o,
	input wire logic [2:0] port_type_o,
	input wire ippc_pkg::ippc_profile_t profile_o,
	input wire logic [1:0] vreq_level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// checks
	// ----
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	property p_byp; buck_bypass_out_o |-> !buck_enable_out_o; endproperty
	a_byp: assert property (p_byp) else $error("buck and bypass both on");
	property p_pwm; !buck_enable_out_o && !$past(buck_enable_out_o) |-> !buck_trim_pwm_out_o; endproperty
	a_pwm: assert property (p_pwm) else $error("trim pwm with buck off");
	property p_vreq; port_type_o inside {3'h2, 3'h3, 3'h4} |-> vreq_level_o != 2'b11; endproperty
	a_vreq: assert property (p_vreq) else $error("usb port above 12v");
	property p_prof; profile_o.bypass_en == (profile_o.max_w == 5'h05); endproperty
	a_prof: assert property (p_prof) else $error("profile mismatch");
	property p_dp; $rose(dplus_sense_pin_oe_o) |=> dplus_sense_pin_oe_o [*8]; endproperty
	a_dp: assert property (p_dp) else $error("d+ drive too short");
	property p_dma; !dminus_sense_pin_a_oe_o; endproperty
	a_dma: assert property (p_dma) else $error("d- sense pin driven");
	property p_fv; fetch_valid_o |=> !fetch_valid_o; endproperty
	a_fv: assert property (p_fv) else $error("fetch valid too long");
	property p_cs; flash_port_pin_0_o |-> !flash_port_pin_1_o; endproperty
	a_cs: assert property (p_cs) else $error("flash clock while idle");
endmodule
bind ippc_top ippc_top_properties i_ippc_top_properties (.mclk_i, .rst_i,
	.dminus_sense_pin_a_oe_o, .dplus_sense_pin_oe_o, .buck_enable_out_o,
	.buck_trim_pwm_out_o, .buck_bypass_out_o, .flash_port_pin_0_o, .flash_port_pin_1_o,
	.fetch_valid_o, .port_type_o, .profile_o, .vreq_level_o);

// File: ippc_flash_model.sv
module ippc_flash_model (
	input wire logic mclk_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	output logic miso_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// serial flash
	// ----
	logic [10:0] falls = '0;
	logic idle_r = 1'b0;
	logic [7:0] dat;
	// released line toggles so a stale bit never reads as data
	always @(posedge mclk_i) idle_r <= ~idle_r;
	always @(negedge sck_i or posedge cs_n_i) begin
		if (cs_n_i)
			falls <= '0;
		else
			falls <= falls + 11'h001;
	end
	assign dat = 8'h5a + 8'(falls >> 3) - 8'h04;
	assign miso_o = cs_n_i ? idle_r : dat[3'h7 - falls[2:0]];
endmodule

// File: tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// bench
	// ----
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic att = 1'b0;
	logic [1:0] lvl = 2'b00;
	logic [2:0] kind = 3'h1;
	logic xin = 1'b0;
	logic scl = 1'b1;
	logic sdh = 1'b1;
	logic fault = 1'b0;
	logic [1:0] old = 2'b00;
	logic dmb_oe, dmb_o, dp_oe, dp_o, sck, cs, miso, sd_oe, fv, bd, status_indicator_two, buck, byp;
	logic [7:0] fd, ping, v, rv;
	logic [2:0] port;
	logic [1:0] vreq;
	ippc_pkg::ippc_profile_t prof;
	logic [4:0] w [4] = '{5'h05, 5'h08, 5'h0a, 5'h0f};
	logic [7:0] q [$];
	int fails = 0;
	int checks_done = 0;
	// adaptor model: d+ pulled up for a plain source, shorted to d- on a dedicated port
	wire dp_w = (dp_oe & dp_o) | (kind == 3'h1) | (kind == 3'h4 & dmb_oe & dmb_o);
	wire dma_w = (kind == 3'h3) ? (dp_oe & dp_o) : (kind == 3'h4) & dp_w;
	wire sda_w = sdh & ~sd_oe;
	ippc_top #(.LED_STEP(8), .BOOT_LEN(4)) i_ippc_top (.mclk_i(clk), .rst_i(rst),
		.adaptor_present_i(att), .input_level_i(lvl), .dminus_sense_pin_a_i(dma_w),
		.dminus_sense_pin_a_o(), .dminus_sense_pin_a_oe_o(),
		.dminus_sense_pin_b_i(dmb_oe & dmb_o), .dminus_sense_pin_b_o(dmb_o),
		.dminus_sense_pin_b_oe_o(dmb_oe), .dplus_sense_pin_i(dp_w), .dplus_sense_pin_o(dp_o),
		.dplus_sense_pin_oe_o(dp_oe), .buck_enable_out_o(buck), .buck_trim_pwm_out_o(),
		.buck_bypass_out_o(byp), .bridge_drive_o(), .crystal_pin_in_i(xin),
		.crystal_pin_out_o(), .xtal_locked_o(), .flash_port_pin_0_o(cs),
		.flash_port_pin_1_o(sck), .flash_port_pin_2_o(), .flash_port_pin_3_i(miso),
		.fetch_data_o(fd), .fetch_valid_o(fv), .boot_done_o(bd), .serial_clock_pin_i(scl),
		.serial_data_pin_i(sda_w), .serial_data_pin_o(), .serial_data_pin_oe_o(sd_oe),
		.former_threshold_pin_i(old[0]), .former_pattern_pin_i(old[1]), .fault_i(fault),
		.status_indicator_one_o(), .status_indicator_two_o(status_indicator_two), .port_type_o(port),
		.profile_o(prof), .vreq_level_o(vreq), .ping_freq_o(ping), .fod_thresh_o(),
		.ilim_o());
	ippc_flash_model i_ippc_flash_model (.mclk_i(clk), .cs_n_i(cs), .sck_i(sck), .miso_o(miso));
	initial forever #25 clk = ~clk;
	always @(posedge clk) xin <= ~xin;
	always @(posedge clk) old <= 2'($urandom);
	always @(posedge clk) if (fv === 1'b1) q.push_back(fd);
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic ph(input logic c, input logic d);
		@(posedge clk);
		scl <= c;
		sdh <= d;
		repeat (5) @(posedge clk);
	endtask
	task automatic wb(input logic [7:0] b, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			ph(1'b0, b[i]);
			ph(1'b1, b[i]);
			ph(1'b0, b[i]);
		end
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		cmp(8'(sda_w), 8'(ack));
		ph(1'b0, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
		wb(a, a != 8'hc2);
		wb(r, a != 8'hc2);
		wb(d, a != 8'hc2);
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
		wb(8'hc2, 1'b0);
		wb(r, 1'b0);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
		wb(8'hc3, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			ph(1'b1, 1'b1);
			d[i] = sda_w;
			ph(1'b0, 1'b1);
		end
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	task automatic det(input logic [2:0] k, input logic [1:0] l);
		int n;
		logic [1:0] e;
		@(posedge clk);
		att <= 1'b0;
		repeat (4) @(posedge clk);
		kind <= k;
		lvl <= l;
		att <= 1'b1;
		n = 0;
		while (port === 3'h0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
		e = (k != 3'h1 && l == 2'b11) ? 2'b10 : l;
		cmp(8'(port), 8'(k));
		cmp(8'(vreq), 8'(e));
		cmp(prof, {e != 2'b00, w[e], e != 2'b00, e == 2'b00});
		cmp(8'({buck, byp}), 8'({e != 2'b00, e == 2'b00}));
		cmp(8'(status_indicator_two), 8'(e != 2'b00));
	endtask
	task automatic final_report;
		$display("fails=%0d checks_done=%0d", fails, checks_done);
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'ha1278524));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			det(i < 4 ? 3'h1 : 3'(i - 2), i < 4 ? 2'(i) : 2'($urandom));
		end
		cmp(8'(bd), 8'h01);
		cmp(8'(q.size()), 8'h04);
		foreach (q[k]) cmp(q[k], 8'h5a + 8'(k));
		v = 8'($urandom);
		wr(8'hc4, 8'h00, ~v);
		cmp(ping, ippc_pkg::PING_RST);
		wr(8'hc2, 8'h00, v);
		cmp(ping, v);
		rd(8'h00, rv);
		cmp(rv, v);
		final_report();
	end
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		final_report();
	end
endmodule
